// File: include/deser_mode_pkg.sv
/*
 * Constants and carrier types for the deserializer mode and self-test
 * register slice. Assumes an 8-bit register address space.
 */
package deser_mode_pkg;

  localparam logic [7:0] DATAPATH_AUDIO_CONTROL_OFS  = 8'h22;
  localparam logic [7:0] RECEIVE_MODE_STATUS_OFS     = 8'h23;
  localparam logic [7:0] SELF_TEST_CONTROL_OFS       = 8'h24;
  localparam logic [7:0] SELF_TEST_ERROR_COUNTER_OFS = 8'h25;

  localparam logic [7:0] DATAPATH_AUDIO_CONTROL_RST  = 8'h00;
  localparam logic [7:0] RECEIVE_MODE_STATUS_RST     = 8'h20;
  localparam logic [7:0] SELF_TEST_CONTROL_RST       = 8'h08;

  // Datapath audio control fields
  localparam int AUD_4CH_BIT     = 0;
  localparam int AUD_INBAND_BIT  = 1;
  localparam int FWD_OVR_BIT     = 7;
  // Receive mode fields
  localparam int REPEATER_BIT    = 2;
  localparam int COAX_BIT        = 3;
  localparam int BC_FAST_BIT     = 4;
  localparam int AUTO_AUDIO_BIT  = 5;
  localparam int BC_RATE_SEL_BIT = 6;
  localparam int LINE_CSUM_BIT   = 7;
  // Self-test control fields
  localparam int ST_EN_BIT       = 0;
  localparam int ST_CLK_LSB      = 1;
  localparam int ST_PIN_CFG_BIT  = 3;
  localparam int OSC_RATE_LSB    = 4;

  // Strap bit positions on the mode strap decode
  localparam int STRAP_FAST_BIT  = 0;
  localparam int STRAP_COAX_BIT  = 1;
  localparam int STRAP_RPT_BIT   = 2;

  localparam logic [7:0] REMOTE_CLK_SRC_OFS = 8'h14;
  localparam int         BC_FAST_MBPS       = 20;

  typedef enum logic [1:0] {
    BC_DIV4 = 2'b00,
    BC_DIV2 = 2'b01,
    BC_FAST = 2'b10
  } bc_rate_e;

  typedef enum logic [1:0] {
    OSC_50MHZ = 2'b00,
    OSC_25MHZ = 2'b01,
    OSC_10MHZ = 2'b10,
    OSC_RSVD  = 2'b11
  } osc_rate_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_PUSH   = 2'b01,
    ST_ACTIVE = 2'b10
  } self_test_e;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       load;
    logic       inband;
    logic       four_ch;
  } fwd_load_s;

  typedef struct packed {
    logic       req;
    logic [7:0] addr;
    logic [1:0] data;
  } remote_wr_s;

endpackage : deser_mode_pkg

// File: rtl/deser_mode_bist_regs.sv
/*
 * Audio, receive-mode and self-test register slice of a link deserializer.
 * Assumes a register port synchronous to SYS_CLK with one-cycle read
 * latency, and a mode strap that is stable at the first clock after RST_B rises.
 */
// Overview of operation
// - Transport bit: 1 in-band, 0 data-island audio
// - Bit 0 enables four-channel audio output
// - Remote reloads audio bits unless override set
// - Override bit blocks forward-channel reloads
// - Checksum enable checks each line, flags mismatches
// - Rate select: 0 divide by 4, 1 by 2
// - Fast bit overrides select, 20 Mbps rate
// - Fast, coax, repeater bits load from strap
// - Auto audio mode follows received aux codes
// - Cable bit: 0 twisted pair, 1 coax
// - Repeater bit read-only, shows strap
// - Oscillator clock field: 50, 25, 10 MHz
// - Self-test config from pin when bit set
// - Enabled self-test pushes clock source remotely
// - Self-test enable bit starts and stops test unless pin config bit set
`timescale 1ns/1ps
module deser_mode_bist_regs
  import deser_mode_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  input  wire reg_req_s   REG_REQ,
  output logic [7:0]      RD_DATA,
  input  wire fwd_load_s  FWD_LOAD,
  input  wire logic [2:0] MODE_STRAP_PIN,
  input  wire logic       LINE_END,
  input  wire logic [7:0] LINE_SUM_CALC,
  input  wire logic [7:0] LINE_SUM_RX,
  output logic            CHECKSUM_FAIL,
  input  wire logic       AUX_VALID,
  input  wire logic [1:0] AUX_AUDIO_CODE,
  output logic [1:0]      AUDIO_IF_MODE,
  output logic            AUDIO_INBAND,
  output logic            AUDIO_4CH_EN,
  output bc_rate_e        BC_RATE,
  output logic            COAX_CABLE,
  output logic            REPEATER,
  input  wire logic       AUTO_CLOCK_EN,
  output osc_rate_e       OSC_RATE,
  output logic            OSC_RATE_VALID,
  input  wire logic       SELF_TEST_PIN,
  input  wire logic [2:0] SELF_TEST_PIN_CFG,
  input  wire logic [7:0] SELF_TEST_ERRORS,
  output logic            SELF_TEST_ACTIVE,
  output remote_wr_s      REMOTE_WR,
  input  wire logic       REMOTE_WR_ACK
);

  logic [7:0] datapath_audio_control;
  logic [7:0] receive_mode_status;
  logic [7:0] self_test_control;
  logic [7:0] self_test_error_counter;
  logic       strap_pending;
  self_test_e st_state;
  logic [2:0] st_cfg;
  logic       st_en;

  function automatic logic hit(input logic [7:0] ofs);
    hit = REG_REQ.wr && (REG_REQ.addr == ofs);
  endfunction : hit

  // Datapath audio control; local write wins over a same-cycle reload
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      datapath_audio_control <= DATAPATH_AUDIO_CONTROL_RST;
    end else if (hit(DATAPATH_AUDIO_CONTROL_OFS)) begin
      datapath_audio_control <= REG_REQ.wdata;
    end else if (FWD_LOAD.load &&
                 !datapath_audio_control[FWD_OVR_BIT]) begin
      datapath_audio_control[AUD_INBAND_BIT] <= FWD_LOAD.inband;
      datapath_audio_control[AUD_4CH_BIT]    <= FWD_LOAD.four_ch;
    end
  end

  // Strap caught on the first clock after release, not under reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      receive_mode_status <= RECEIVE_MODE_STATUS_RST;
      strap_pending       <= 1'b1;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      receive_mode_status[BC_FAST_BIT]  <= MODE_STRAP_PIN[STRAP_FAST_BIT];
      receive_mode_status[COAX_BIT]     <= MODE_STRAP_PIN[STRAP_COAX_BIT];
      receive_mode_status[REPEATER_BIT] <= MODE_STRAP_PIN[STRAP_RPT_BIT];
    end else if (hit(RECEIVE_MODE_STATUS_OFS)) begin
      receive_mode_status[7:3] <= REG_REQ.wdata[7:3];
      receive_mode_status[1:0] <= REG_REQ.wdata[1:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      self_test_control       <= SELF_TEST_CONTROL_RST;
      self_test_error_counter <= 8'h00;
    end else begin
      if (hit(SELF_TEST_CONTROL_OFS)) begin
        self_test_control <= REG_REQ.wdata;
      end
      self_test_error_counter <= SELF_TEST_ERRORS;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      RD_DATA <= 8'h00;
    end else if (REG_REQ.addr == DATAPATH_AUDIO_CONTROL_OFS) begin
      RD_DATA <= datapath_audio_control;
    end else if (REG_REQ.addr == RECEIVE_MODE_STATUS_OFS) begin
      RD_DATA <= receive_mode_status;
    end else if (REG_REQ.addr == SELF_TEST_CONTROL_OFS) begin
      RD_DATA <= self_test_control;
    end else if (REG_REQ.addr == SELF_TEST_ERROR_COUNTER_OFS) begin
      RD_DATA <= self_test_error_counter;
    end else begin
      RD_DATA <= 8'h00;
    end
  end

  // Audio and link configuration outputs
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      AUDIO_INBAND <= 1'b0;
      AUDIO_4CH_EN <= 1'b0;
      COAX_CABLE   <= 1'b0;
      REPEATER     <= 1'b0;
      BC_RATE      <= BC_DIV4;
    end else begin
      AUDIO_INBAND <= datapath_audio_control[AUD_INBAND_BIT];
      AUDIO_4CH_EN <= datapath_audio_control[AUD_4CH_BIT];
      COAX_CABLE   <= receive_mode_status[COAX_BIT];
      REPEATER     <= receive_mode_status[REPEATER_BIT];
      if (receive_mode_status[BC_FAST_BIT]) begin
        BC_RATE <= BC_FAST;
      end else if (receive_mode_status[BC_RATE_SEL_BIT]) begin
        BC_RATE <= BC_DIV2;
      end else begin
        BC_RATE <= BC_DIV4;
      end
    end
  end

  // Rate change hazard on the control channel is the controller's care
  // this slice only applies the new rate.

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      CHECKSUM_FAIL <= 1'b0;
    end else begin
      CHECKSUM_FAIL <= receive_mode_status[LINE_CSUM_BIT] && LINE_END &&
                       (LINE_SUM_CALC != LINE_SUM_RX);
    end
  end

  // Manual mode keeps the last detected audio mode
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      AUDIO_IF_MODE <= 2'b00;
    end else if (receive_mode_status[AUTO_AUDIO_BIT] && AUX_VALID) begin
      AUDIO_IF_MODE <= AUX_AUDIO_CODE;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      OSC_RATE       <= OSC_50MHZ;
      OSC_RATE_VALID <= 1'b0;
    end else begin
      OSC_RATE <= osc_rate_e'(self_test_control[OSC_RATE_LSB +: 2]);
      OSC_RATE_VALID <= AUTO_CLOCK_EN &&
        (self_test_control[OSC_RATE_LSB +: 2] != OSC_RSVD);
    end
  end

  // Effective self-test configuration: pin or register
  always_comb begin
    if (self_test_control[ST_PIN_CFG_BIT]) begin
      st_cfg = SELF_TEST_PIN_CFG;
      st_en  = SELF_TEST_PIN;
    end else begin
      st_cfg = self_test_control[2:0];
      st_en  = self_test_control[ST_EN_BIT];
    end
  end

  // Clock source push holds until the remote write is acknowledged or the test enable drops
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      st_state         <= ST_IDLE;
      SELF_TEST_ACTIVE <= 1'b0;
      REMOTE_WR        <= '0;
    end else begin
      case (st_state)
        ST_IDLE: begin
          if (st_en) begin
            st_state       <= ST_PUSH;
            REMOTE_WR.req  <= 1'b1;
            REMOTE_WR.addr <= REMOTE_CLK_SRC_OFS;
            REMOTE_WR.data <= st_cfg[ST_CLK_LSB +: 2];
          end
        end
        ST_PUSH: begin
          if (!st_en) begin
            st_state      <= ST_IDLE;
            REMOTE_WR.req <= 1'b0;
          end else if (REMOTE_WR_ACK) begin
            st_state         <= ST_ACTIVE;
            REMOTE_WR.req    <= 1'b0;
            SELF_TEST_ACTIVE <= 1'b1;
          end
        end
        ST_ACTIVE: begin
          if (!st_en) begin
            st_state         <= ST_IDLE;
            SELF_TEST_ACTIVE <= 1'b0;
          end
        end
        default: begin
          st_state <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  reload_blocked_a: assert property (
    datapath_audio_control[FWD_OVR_BIT] && FWD_LOAD.load &&
    !hit(DATAPATH_AUDIO_CONTROL_OFS) |=> $stable(datapath_audio_control))
    else $error("Reload changed register while override set");
  reload_taken_a: assert property (
    !datapath_audio_control[FWD_OVR_BIT] && FWD_LOAD.load &&
    !hit(DATAPATH_AUDIO_CONTROL_OFS) |=> ##1
    AUDIO_INBAND == $past(FWD_LOAD.inband, 2) &&
    AUDIO_4CH_EN == $past(FWD_LOAD.four_ch, 2))
    else $error("Forward reload not applied to audio outputs");
  fast_rate_a: assert property (
    receive_mode_status[BC_FAST_BIT] |=> BC_RATE == BC_FAST)
    else $error("Fast back channel not selected");
  slow_rate_a: assert property (
    !receive_mode_status[BC_FAST_BIT] |=> BC_RATE ==
    ($past(receive_mode_status[BC_RATE_SEL_BIT]) ? BC_DIV2 : BC_DIV4))
    else $error("Back channel divider wrong");
  checksum_flag_a: assert property (
    CHECKSUM_FAIL |-> $past(receive_mode_status[LINE_CSUM_BIT] &&
    LINE_END && LINE_SUM_CALC != LINE_SUM_RX))
    else $error("Checksum failure without cause");
  repeater_ro_a: assert property (
    !strap_pending |=> $stable(receive_mode_status[REPEATER_BIT]))
    else $error("Repeater bit changed after strap");
  strap_load_a: assert property (
    strap_pending |=> receive_mode_status[COAX_BIT] ==
    $past(MODE_STRAP_PIN[STRAP_COAX_BIT]) ##1 COAX_CABLE ==
    $past(MODE_STRAP_PIN[STRAP_COAX_BIT], 2))
    else $error("Coax bit not taken from strap");
  push_addr_a: assert property (
    st_state == ST_IDLE && st_en |=> REMOTE_WR.req &&
    REMOTE_WR.addr == REMOTE_CLK_SRC_OFS)
    else $error("Clock source push not issued");
  stop_test_a: assert property (
    st_state == ST_ACTIVE && !st_en |=> !SELF_TEST_ACTIVE)
    else $error("Self-test did not stop");
  osc_valid_a: assert property (
    OSC_RATE_VALID |-> $past(AUTO_CLOCK_EN) && OSC_RATE != OSC_RSVD)
    else $error("Oscillator rate valid when not allowed");
  // Output mirrors lag their register by one edge; skip the release edge
  inband_out_a: assert property (
    $past(RST_B) |->
    AUDIO_INBAND == $past(datapath_audio_control[AUD_INBAND_BIT]))
    else $error("In-band transport output wrong");
  four_ch_out_a: assert property (
    $past(RST_B) |->
    AUDIO_4CH_EN == $past(datapath_audio_control[AUD_4CH_BIT]))
    else $error("Four-channel output wrong");
  coax_out_a: assert property (
    $past(RST_B) |->
    COAX_CABLE == $past(receive_mode_status[COAX_BIT]))
    else $error("Cable type output wrong");
  auto_audio_a: assert property (
    receive_mode_status[AUTO_AUDIO_BIT] && AUX_VALID |=>
    AUDIO_IF_MODE == $past(AUX_AUDIO_CODE))
    else $error("Aux code not taken in auto mode");
  manual_hold_a: assert property (
    !receive_mode_status[AUTO_AUDIO_BIT] |=> $stable(AUDIO_IF_MODE))
    else $error("Audio mode changed in manual mode");
  pin_config_a: assert property (
    self_test_control[ST_PIN_CFG_BIT] && st_state == ST_IDLE &&
    SELF_TEST_PIN |=> REMOTE_WR.req &&
    REMOTE_WR.data == $past(SELF_TEST_PIN_CFG[2:1]))
    else $error("Pin self-test config not pushed");
  push_hold_a: assert property (
    st_state == ST_PUSH && st_en && !REMOTE_WR_ACK |=>
    REMOTE_WR.req && $stable(REMOTE_WR.data))
    else $error("Clock source push dropped before ack");

  reload_c: cover property (FWD_LOAD.load && !hit(DATAPATH_AUDIO_CONTROL_OFS));
  push_c:   cover property (st_state == ST_PUSH ##[1:8] SELF_TEST_ACTIVE);
  csum_c:   cover property (CHECKSUM_FAIL);
  strap_c:  cover property (strap_pending ##1 receive_mode_status[BC_FAST_BIT]);
  pin_c:    cover property (self_test_control[ST_PIN_CFG_BIT] &&
                            SELF_TEST_ACTIVE);

endmodule : deser_mode_bist_regs

// File: verif/remote_ser_model.sv
/*
 * Remote serializer stand-in that takes clock-source pushes.
 * Assumes the block's clock and reset; acks after ACK_DELAY cycles.
 */
`timescale 1ns/1ps
module remote_ser_model
  import deser_mode_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  input  wire remote_wr_s REMOTE_WR,
  input  wire logic [3:0] ACK_DELAY,
  output logic            REMOTE_WR_ACK,
  output logic [1:0]      CLK_SRC
);
  logic [3:0] wait_cnt;

  // Falling edge, same as every other input of the block
  always_ff @(negedge SYS_CLK) begin
    if (!RST_B) begin
      REMOTE_WR_ACK <= 1'b0;
      wait_cnt      <= 4'h0;
      CLK_SRC       <= 2'b00;
    end else begin
      REMOTE_WR_ACK <= 1'b0;
      if (!REMOTE_WR.req) begin
        wait_cnt <= 4'h0;
      end else if (!REMOTE_WR_ACK) begin
        if (wait_cnt == ACK_DELAY) begin
          REMOTE_WR_ACK <= 1'b1;
          wait_cnt      <= 4'h0;
          if (REMOTE_WR.addr == REMOTE_CLK_SRC_OFS) begin
            CLK_SRC <= REMOTE_WR.data;
          end
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule : remote_ser_model

// File: verif/deser_mode_bist_regs_bench.sv
/*
 * Self-checking bench for the mode and self-test register slice.
 * Assumes the remote serializer model beside it.
 */
`timescale 1ns/1ps
module deser_mode_bist_regs_bench
  import deser_mode_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst_b, line_end, csum_fail, aux_valid, inband, four_ch;
  logic       coax, rpt, auto_clk, osc_valid, st_pin, st_active, rwr_ack;
  reg_req_s   req;
  fwd_load_s  fwd;
  remote_wr_s rwr;
  bc_rate_e   bc_rate;
  osc_rate_e  osc_rate;
  logic [7:0] rd_data, sum_calc, sum_rx, st_err;
  logic [2:0] strap, st_cfg;
  logic [1:0] aux_code, if_mode, clk_src;
  logic [3:0] ack_dly;
  int         num_errors, total_checks;

  always #5 sys_clk = ~sys_clk;

  deser_mode_bist_regs i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .REG_REQ(req), .RD_DATA(rd_data), .FWD_LOAD(fwd),
    .MODE_STRAP_PIN(strap), .LINE_END(line_end), .LINE_SUM_CALC(sum_calc),
    .LINE_SUM_RX(sum_rx), .CHECKSUM_FAIL(csum_fail),
    .AUX_VALID(aux_valid), .AUX_AUDIO_CODE(aux_code),
    .AUDIO_IF_MODE(if_mode), .AUDIO_INBAND(inband), .AUDIO_4CH_EN(four_ch),
    .BC_RATE(bc_rate), .COAX_CABLE(coax), .REPEATER(rpt),
    .AUTO_CLOCK_EN(auto_clk), .OSC_RATE(osc_rate),
    .OSC_RATE_VALID(osc_valid), .SELF_TEST_PIN(st_pin),
    .SELF_TEST_PIN_CFG(st_cfg), .SELF_TEST_ERRORS(st_err),
    .SELF_TEST_ACTIVE(st_active), .REMOTE_WR(rwr),
    .REMOTE_WR_ACK(rwr_ack));

  remote_ser_model i_remote (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .REMOTE_WR(rwr), .ACK_DELAY(ack_dly), .REMOTE_WR_ACK(rwr_ack),
    .CLK_SRC(clk_src));

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : ticks

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{1'b1, a, d};
    @(negedge sys_clk);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, string s);
    @(negedge sys_clk);
    req.addr = a;
    @(negedge sys_clk);
    chk(s, e, rd_data);
  endtask : rd

  task automatic t_reset;
    rd(8'h22, 8'h00, "audio reg");
    rd(8'h23, 8'h34, "mode reg");
    rd(8'h24, 8'h08, "test reg");
    chk("rate", {6'h0, BC_FAST}, {6'h0, bc_rate});
    chk("repeater", 8'h01, {7'h0, rpt});
    $display("reset test done");
  endtask : t_reset

  task automatic t_mode;
    logic [7:0] w[4] = '{8'h20, 8'h60, 8'h70, 8'h2B};
    logic [7:0] e[4] = '{8'h24, 8'h64, 8'h74, 8'h2F};
    bc_rate_e   b[4] = '{BC_DIV4, BC_DIV2, BC_FAST, BC_DIV4};
    for (int i = 0; i < 4; i++) begin
      wr(8'h23, w[i]);
      rd(8'h23, e[i], "mode reg");
      ticks(1);
      chk("rate", {6'h0, b[i]}, {6'h0, bc_rate});
      chk("coax", {7'h0, w[i][3]}, {7'h0, coax});
    end
    $display("mode test done");
  endtask : t_mode

  task automatic load(input logic i, input logic f);
    @(negedge sys_clk);
    fwd = '{1'b1, i, f};
    @(negedge sys_clk);
    fwd.load = 1'b0;
    ticks(2);
  endtask : load

  task automatic t_audio;
    wr(8'h22, 8'h03);
    ticks(2);
    chk("inband", 8'h01, {7'h0, inband});
    chk("four ch", 8'h01, {7'h0, four_ch});
    wr(8'h22, 8'h00);
    load(1'b1, 1'b0);
    chk("inband", 8'h01, {7'h0, inband});
    chk("four ch", 8'h00, {7'h0, four_ch});
    wr(8'h22, 8'h80);
    load(1'b1, 1'b1);
    rd(8'h22, 8'h80, "audio reg");
    chk("four ch", 8'h00, {7'h0, four_ch});
    $display("audio test done");
  endtask : t_audio

  task automatic line(input logic [7:0] r, input logic e);
    @(negedge sys_clk);
    {line_end, sum_calc, sum_rx} = {1'b1, 8'h3C, r};
    @(negedge sys_clk);
    line_end = 1'b0;
    chk("csum fail", {7'h0, e}, {7'h0, csum_fail});
    ticks(1);
    chk("csum fail", 8'h00, {7'h0, csum_fail});
  endtask : line

  task automatic aux(input logic [1:0] c, input logic [1:0] e);
    @(negedge sys_clk);
    {aux_valid, aux_code} = {1'b1, c};
    @(negedge sys_clk);
    aux_valid = 1'b0;
    ticks(1);
    chk("aux mode", {6'h0, e}, {6'h0, if_mode});
  endtask : aux

  task automatic t_line_aux;
    wr(8'h23, 8'hA0);
    line(8'h3D, 1'b1);
    line(8'h3C, 1'b0);
    aux(2'b10, 2'b10);
    aux(2'b01, 2'b01);
    wr(8'h23, 8'h00);
    line(8'h3D, 1'b0);
    aux(2'b11, 2'b01);
    wr(8'h23, 8'h20);
    $display("line and aux test done");
  endtask : t_line_aux

  task automatic t_osc;
    auto_clk = 1'b1;
    for (int f = 0; f < 4; f++) begin
      wr(8'h24, 8'(f << 4));
      ticks(2);
      chk("osc rate", 8'(f), {6'h0, osc_rate});
      chk("osc valid", {7'h0, f != 3}, {7'h0, osc_valid});
    end
    auto_clk = 1'b0;
    $display("osc test done");
  endtask : t_osc

  task automatic st_run(input logic [1:0] src);
    int n = 0;
    while (rwr.req !== 1'b1 && n < 20) begin
      ticks(1);
      n++;
    end
    chk("push addr", REMOTE_CLK_SRC_OFS, rwr.addr);
    chk("push data", {6'h0, src}, {6'h0, rwr.data});
    while (st_active !== 1'b1 && n < 40) begin
      ticks(1);
      n++;
    end
    chk("remote src", {6'h0, src}, {6'h0, clk_src});
    chk("active", 8'h01, {7'h0, st_active});
  endtask : st_run

  task automatic t_self;
    wr(8'h24, 8'h05);
    st_run(2'b10);
    wr(8'h24, 8'h04);
    ticks(2);
    chk("active", 8'h00, {7'h0, st_active});
    ack_dly = 4'h5;
    st_cfg = 3'b011;
    st_pin = 1'b1;
    wr(8'h24, 8'h08);
    st_run(2'b01);
    st_pin = 1'b0;
    ticks(2);
    chk("active", 8'h00, {7'h0, st_active});
    rd(8'h25, 8'h5A, "error count");
    wr(8'h25, 8'h00);
    rd(8'h25, 8'h5A, "error count");
    rd(8'h30, 8'h00, "unmapped");
    $display("self-test test done");
  endtask : t_self

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rst_b, line_end, aux_valid, auto_clk, st_pin} = 5'h0;
    {req, fwd, sum_calc, sum_rx, aux_code, st_cfg} = '0;
    {strap, st_err, ack_dly} = {3'b101, 8'h5A, 4'h0};
    ticks(20);
    rst_b = 1'b1;
    ticks(2);
    t_reset();
    t_mode();
    t_audio();
    t_line_aux();
    t_osc();
    t_self();
    complete_run();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    num_errors++;
    $display("watchdog expired");
    complete_run();
  end
endmodule : deser_mode_bist_regs_bench
